// >>> ddrpi_defines.svh
// Function
// - Chip select is driven low only while a memory command is issued.
// - Sixteen-bit data bus moves one word on each memory clock edge.
// - Two byte masks drive during writes; bit 0 low byte, bit 1 high byte.
// - Strobes driven by controller on writes, sampled as inputs on reads.
// - Strobe 0 clocks data bits 7:0, strobe 1 clocks bits 15:8.
// - Row address strobe is asserted low within the issued command encoding.
// - Memory clock leaves as a differential pair in opposite phase.
// - Column address strobe is asserted low within the issued command encoding.
// - Clock enable low after cold reset and during power down, else high.
// - Write enable is asserted low during write commands.
`ifndef DDRPI_DEFINES_SVH
`define DDRPI_DEFINES_SVH
`define DDRPI_SYS_CLK_PERIOD_NS 10
`define DDRPI_MEM_CLK_PERIOD_NS 125
`define DDRPI_MEM_CLK_HALF_CYC ((`DDRPI_MEM_CLK_PERIOD_NS / 2) / `DDRPI_SYS_CLK_PERIOD_NS)
`define DDRPI_DQ_WIDTH 16
`define DDRPI_LANES 2
`define DDRPI_FIFO_DEPTH 16
`define DDRPI_BURST_WORDS 2
`endif

// >>> ddrpi_pkg.sv
package ddrpi_pkg;
	typedef struct packed {
		logic [1:0] byte_mask;
		logic [15:0] data;
	} ddrpi_wr_word_t;
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} ddrpi_cmd_pins_t;
	typedef enum logic {
		ddrpi_op_read,
		ddrpi_op_write
	} ddrpi_op_t;
	typedef enum logic [2:0] {
		st_idle,
		st_act,
		st_cmd,
		st_wdata,
		st_rwait
	} ddrpi_state_t;
endpackage

// >>> ddrpi_top.sv
`timescale 1ns/100ps
`include "ddrpi_defines.svh"

module ddrpi_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = `DDRPI_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr, rd_ptr;
	logic push, pop;
	assign level = wr_ptr - rd_ptr;
	assign in_ready = (level != (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign push = clk_en && in_valid && in_ready;
	assign pop = clk_en && out_valid && out_ready;
	assign out_data = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

module ddrpi_top #(
	parameter int HALF_CYC = `DDRPI_MEM_CLK_HALF_CYC,
	parameter int DEPTH = `DDRPI_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire ddrpi_pkg::ddrpi_wr_word_t wr_word,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire ddrpi_pkg::ddrpi_op_t cmd_op,
	input wire logic pwr_down,
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic mem_clk_pos,
	output logic mem_clk_neg,
	output logic mem_clk_en,
	output logic mem_chip_sel_n,
	output logic mem_row_strobe_n,
	output logic mem_col_strobe_n,
	output logic mem_write_en_n,
	output logic [1:0] mem_byte_mask,
	input wire logic [15:0] mem_dq_i,
	output logic [15:0] mem_dq_o,
	output logic [15:0] mem_dq_oe,
	input wire logic [1:0] mem_byte_strobe_i,
	output logic [1:0] mem_byte_strobe_o,
	output logic [1:0] mem_byte_strobe_oe
);
	localparam int LANES = `DDRPI_LANES;
	ddrpi_pkg::ddrpi_state_t state, next_state;
	ddrpi_pkg::ddrpi_op_t op;
	ddrpi_pkg::ddrpi_cmd_pins_t pins;
	ddrpi_pkg::ddrpi_wr_word_t fifo_word;
	logic [$clog2(DEPTH):0] fifo_level;
	logic fifo_valid, pop, enter_write;
	logic [7:0] half_cnt;
	logic tick, rise, fall, next_clk;
	logic [1:0] dqs_s1, dqs_s2, dqs_s3;
	logic [15:0] dq_s1, dq_s2;
	logic [1:0] lane_done;
	logic [1:0] dqs_cnt [LANES];
	logic [7:0] rd_first [LANES], rd_second [LANES];
	function automatic ddrpi_pkg::ddrpi_cmd_pins_t cmd_decode(ddrpi_pkg::ddrpi_state_t st,
			ddrpi_pkg::ddrpi_op_t o);
		cmd_decode = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
		if (st == ddrpi_pkg::st_act) begin
			cmd_decode = '{cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b1, we_n: 1'b1};
		end else if (st == ddrpi_pkg::st_cmd) begin
			cmd_decode = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b0,
				we_n: (o != ddrpi_pkg::ddrpi_op_write)};
		end
	endfunction

	ddrpi_fifo #(.WIDTH($bits(ddrpi_pkg::ddrpi_wr_word_t)), .DEPTH(DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_word),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_word),
		.level(fifo_level)
	);

	// Memory clock is divided down from sys_clk; edges are known one cycle ahead
	assign tick = (half_cnt == 8'(HALF_CYC - 1));
	assign rise = tick && !mem_clk_pos;
	assign fall = tick && mem_clk_pos;
	assign next_clk = tick ? !mem_clk_pos : mem_clk_pos;
	assign mem_clk_neg = !mem_clk_pos;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			half_cnt <= 8'h00;
			mem_clk_pos <= 1'b0;
		end else if (clk_en) begin
			half_cnt <= tick ? 8'h00 : half_cnt + 8'h01;
			mem_clk_pos <= next_clk;
		end
	end

	// A write only starts once both words of the burst are buffered
	assign cmd_ready = (state == ddrpi_pkg::st_idle) && rise && mem_clk_en && !pwr_down &&
		(cmd_op == ddrpi_pkg::ddrpi_op_read || fifo_level >= `DDRPI_BURST_WORDS);
	assign lane_done = {dqs_cnt[1] == 2'h2, dqs_cnt[0] == 2'h2};
	always_comb begin
		next_state = state;
		case (state)
			ddrpi_pkg::st_idle: begin
				next_state = (cmd_valid && cmd_ready) ? ddrpi_pkg::st_act : state;
			end
			ddrpi_pkg::st_act: begin
				next_state = rise ? ddrpi_pkg::st_cmd : state;
			end
			ddrpi_pkg::st_cmd: begin
				if (rise) begin
					next_state = (op == ddrpi_pkg::ddrpi_op_write) ? ddrpi_pkg::st_wdata :
						ddrpi_pkg::st_rwait;
				end
			end
			ddrpi_pkg::st_wdata: begin
				next_state = rise ? ddrpi_pkg::st_idle : state;
			end
			ddrpi_pkg::st_rwait: begin
				next_state = (lane_done == 2'h3) ? ddrpi_pkg::st_idle : state;
			end
			default: begin
				next_state = ddrpi_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= ddrpi_pkg::st_idle;
			op <= ddrpi_pkg::ddrpi_op_read;
		end else if (clk_en) begin
			state <= next_state;
			if (cmd_valid && cmd_ready) begin
				op <= cmd_op;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pins <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
		end else if (clk_en) begin
			pins <= cmd_decode(next_state, (state == ddrpi_pkg::st_idle) ? cmd_op : op);
		end
	end
	assign {mem_chip_sel_n, mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n} = pins;

	// Power-down only takes effect between commands, never mid burst
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mem_clk_en <= 1'b0;
		end else if (clk_en && state == ddrpi_pkg::st_idle) begin
			mem_clk_en <= !pwr_down;
		end
	end

	// First word leaves on the rising edge, second on the falling edge
	assign enter_write = (state == ddrpi_pkg::st_cmd) && (next_state == ddrpi_pkg::st_wdata);
	assign pop = (enter_write || (state == ddrpi_pkg::st_wdata && fall)) && fifo_valid;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mem_dq_o <= 16'h0000;
			mem_byte_mask <= 2'h0;
			mem_dq_oe <= 16'h0000;
			mem_byte_strobe_o <= 2'h0;
			mem_byte_strobe_oe <= 2'h0;
		end else if (clk_en) begin
			if (pop) begin
				mem_dq_o <= fifo_word.data;
				mem_byte_mask <= fifo_word.byte_mask;
			end else if (next_state != ddrpi_pkg::st_wdata) begin
				mem_byte_mask <= 2'h0;
			end
			mem_dq_oe <= {16{next_state == ddrpi_pkg::st_wdata}};
			mem_byte_strobe_oe <= {LANES{next_state == ddrpi_pkg::st_wdata}};
			mem_byte_strobe_o <= (next_state == ddrpi_pkg::st_wdata) ? {LANES{next_clk}} : 2'h0;
		end
	end

	// Strobes and data arrive from the pins, so both pass two flops before use
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dqs_s1 <= 2'h0;
			dqs_s2 <= 2'h0;
			dqs_s3 <= 2'h0;
			dq_s1 <= 16'h0000;
			dq_s2 <= 16'h0000;
		end else if (clk_en) begin
			dqs_s1 <= mem_byte_strobe_i;
			dqs_s2 <= dqs_s1;
			dqs_s3 <= dqs_s2;
			dq_s1 <= mem_dq_i;
			dq_s2 <= dq_s1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					dqs_cnt[g] <= 2'h0;
					rd_first[g] <= 8'h00;
					rd_second[g] <= 8'h00;
				end else if (clk_en) begin
					if (state != ddrpi_pkg::st_rwait) begin
						dqs_cnt[g] <= 2'h0;
					end else if ((dqs_s2[g] ^ dqs_s3[g]) && dqs_cnt[g] != 2'h2) begin
						dqs_cnt[g] <= dqs_cnt[g] + 2'h1;
						// Each strobe captures only its own byte lane
						if (dqs_cnt[g] == 2'h0) begin
							rd_first[g] <= dq_s2[8*g +: 8];
						end else begin
							rd_second[g] <= dq_s2[8*g +: 8];
						end
					end
				end
			end
		end
	endgenerate
	assign rd_data = {rd_second[1], rd_second[0], rd_first[1], rd_first[0]};

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_valid <= 1'b0;
		end else if (clk_en) begin
			rd_valid <= (state == ddrpi_pkg::st_rwait) && (lane_done == 2'h3);
		end
	end

	a_clk_diff_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mem_clk_pos != mem_clk_neg) else $error("memory clock legs not complementary");
	a_chip_sel_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!mem_chip_sel_n |-> (state == ddrpi_pkg::st_act || state == ddrpi_pkg::st_cmd))
		else $error("chip select low outside a command");
	a_row_strobe_act: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state == ddrpi_pkg::st_act |-> !mem_row_strobe_n && mem_col_strobe_n)
		else $error("row strobe wrong during activate");
	a_col_strobe_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state == ddrpi_pkg::st_cmd |-> !mem_col_strobe_n && mem_row_strobe_n)
		else $error("column strobe wrong during command");
	a_write_en_op: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!mem_write_en_n |-> op == ddrpi_pkg::ddrpi_op_write && state == ddrpi_pkg::st_cmd)
		else $error("write enable low without a write command");
	a_clk_en_reset: assert property (@(posedge sys_clk)
		$rose(rst_n) |-> !mem_clk_en) else $error("clock enable high after reset");
	a_bus_release_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state != ddrpi_pkg::st_wdata |-> mem_dq_oe == 16'h0000 && mem_byte_strobe_oe == 2'h0)
		else $error("bus driven outside write data");
	a_mask_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mem_dq_oe == 16'h0000 |-> mem_byte_mask == 2'h0) else $error("mask set outside write");
	a_write_two_words: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
		(state == ddrpi_pkg::st_wdata && fall) |-> pop) else $error("second write word not sent");
	a_read_lane_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_valid |-> $past(state) == ddrpi_pkg::st_rwait && $past(lane_done) == 2'h3)
		else $error("read data returned before both lanes");
endmodule

// >>> ddrpi_mem_model.sv
`timescale 1ns/100ps
module ddrpi_mem_model #(
	parameter real HALF_NS = 62.5,
	parameter real LAT_NS = 30.0,
	parameter real SKEW_NS = 80.0
) (
	input wire logic mem_clk_pos,
	input wire logic mem_chip_sel_n,
	input wire logic mem_col_strobe_n,
	input wire logic mem_write_en_n,
	input wire logic [15:0] rd_word0,
	input wire logic [15:0] rd_word1,
	output logic [15:0] dq_drv,
	output logic [1:0] strobe_drv
);
	initial begin
		dq_drv = 16'h0000;
		strobe_drv = 2'h0;
	end
	// Upper lane lags the lower one, so a strobe clocking the wrong lane misreads
	task automatic drive_lane(int g);
		#(LAT_NS + g * SKEW_NS) dq_drv[8*g +: 8] = rd_word0[8*g +: 8];
		#(HALF_NS) strobe_drv[g] = 1'b1;
		#(LAT_NS) dq_drv[8*g +: 8] = rd_word1[8*g +: 8];
		#(HALF_NS - LAT_NS) strobe_drv[g] = 1'b0;
		// Strobes park low as on a terminated postamble; data shows junk
		#(LAT_NS) dq_drv[8*g +: 8] = ~rd_word1[8*g +: 8];
	endtask
	// Falling edge sees the command mid-period, clear of the launch edge
	always @(negedge mem_clk_pos) begin
		if (mem_chip_sel_n === 1'b0 && mem_col_strobe_n === 1'b0 && mem_write_en_n === 1'b1) begin
			fork
				drive_lane(0);
				drive_lane(1);
			join
		end
	end
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
	logic sys_clk, rst_n, clk_en, wr_valid, wr_ready, cmd_valid, cmd_ready, pwr_down, rd_valid;
	ddrpi_pkg::ddrpi_wr_word_t wr_word;
	ddrpi_pkg::ddrpi_op_t cmd_op;
	logic [31:0] rd_data;
	logic clk_p, clk_n, cke, cs_n, ras_n, cas_n, we_n;
	logic [1:0] mask, dqs_i, dqs_o, dqs_oe, dqs_m;
	logic [15:0] dq_i, dq_o, dq_oe, dq_m;
	int n_fail = 0, n_compared = 0, cycles = 0, n;
	// Each wire bit resolves to whichever side enables it
	assign dq_i = (dq_o & dq_oe) | (dq_m & ~dq_oe);
	assign dqs_i = (dqs_o & dqs_oe) | (dqs_m & ~dqs_oe);
	ddrpi_top #(.HALF_CYC(2), .DEPTH(16)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .pwr_down(pwr_down), .rd_valid(rd_valid),
		.rd_data(rd_data), .mem_clk_pos(clk_p), .mem_clk_neg(clk_n), .mem_clk_en(cke),
		.mem_chip_sel_n(cs_n), .mem_row_strobe_n(ras_n), .mem_col_strobe_n(cas_n),
		.mem_write_en_n(we_n), .mem_byte_mask(mask), .mem_dq_i(dq_i), .mem_dq_o(dq_o),
		.mem_dq_oe(dq_oe), .mem_byte_strobe_i(dqs_i), .mem_byte_strobe_o(dqs_o),
		.mem_byte_strobe_oe(dqs_oe));
	ddrpi_mem_model mem (.mem_clk_pos(clk_p), .mem_chip_sel_n(cs_n), .mem_col_strobe_n(cas_n),
		.mem_write_en_n(we_n), .rd_word0(16'h3C5A), .rd_word1(16'hA5C3), .dq_drv(dq_m),
		.strobe_drv(dqs_m));
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask
	function automatic ddrpi_pkg::ddrpi_wr_word_t word(int i);
		return {2'(i), 4'hA, 4'(i), 4'h5, 4'(i)};
	endfunction
	task automatic issue(ddrpi_pkg::ddrpi_op_t op);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		#1;
		for (n = 0; n < 60 && cmd_ready !== 1'b1; n++) tick();
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		#1;
		check("act_cs_n", cs_n, 1'h0);
		check("act_ras_n", ras_n, 1'h0);
	endtask
	task automatic t_reset();
		logic p;
		check("idle_pins", {cs_n, ras_n, cas_n, we_n}, 4'hF);
		check("idle_oe", {dq_oe, dqs_oe}, 18'h0);
		check("cke_run", cke, 1'h1);
		for (int i = 0; i < 4; i++) begin
			p = clk_p;
			check("clk_pair", clk_n, !clk_p);
			tick();
			tick();
			check("clk_toggle", clk_p, !p);
		end
	endtask
	task automatic t_fill_write();
		ddrpi_pkg::ddrpi_wr_word_t w0, w1;
		for (int i = 0; i < 16; i++) begin
			@(posedge sys_clk);
			wr_valid <= 1'b1;
			wr_word <= word(i);
		end
		@(posedge sys_clk);
		wr_valid <= 1'b0;
		#1;
		check("fifo_full", wr_ready, 1'h0);
		for (int k = 0; k < 8; k++) begin
			w0 = word(2 * k);
			w1 = word(2 * k + 1);
			issue(ddrpi_pkg::ddrpi_op_write);
			for (n = 0; n < 40 && we_n !== 1'b0; n++) tick();
			check("wr_cs_n", cs_n, 1'h0);
			check("wr_cas_n", cas_n, 1'h0);
			check("wr_we_n", we_n, 1'h0);
			for (n = 0; n < 40 && dq_oe !== 16'hFFFF; n++) tick();
			check("w0_dq", dq_o, w0.data);
			check("w0_mask", mask, w0.byte_mask);
			check("w0_dqs", {dqs_oe, dqs_o}, 4'hF);
			for (n = 0; n < 40 && dqs_o !== 2'h0; n++) tick();
			check("w1_dq", dq_o, w1.data);
			check("w1_mask", mask, w1.byte_mask);
			for (n = 0; n < 40 && dq_oe !== 16'h0; n++) tick();
			check("wr_release", {mask, dqs_oe, cs_n}, 5'h1);
		end
		check("fifo_drained", wr_ready, 1'h1);
	endtask
	task automatic t_read();
		issue(ddrpi_pkg::ddrpi_op_read);
		for (n = 0; n < 100 && rd_valid !== 1'b1; n++) begin
			tick();
			check("rd_no_drive", {dq_oe, dqs_oe}, 18'h0);
		end
		// Distinct bytes per lane expose a swapped strobe-to-lane mapping
		check("rd_data", rd_data, 32'hA5C33C5A);
		check("rd_cs_n", cs_n, 1'h1);
	endtask
	task automatic t_power();
		@(posedge sys_clk);
		pwr_down <= 1'b1;
		for (n = 0; n < 20 && cke !== 1'b0; n++) tick();
		check("pd_cke", cke, 1'h0);
		for (int i = 0; i < 8; i++) begin
			tick();
			check("pd_no_cmd", cmd_ready, 1'h0);
		end
		@(posedge sys_clk);
		pwr_down <= 1'b0;
		for (n = 0; n < 20 && cke !== 1'b1; n++) tick();
		check("pu_cke", cke, 1'h1);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		wr_valid = 1'b0;
		wr_word = '0;
		cmd_valid = 1'b0;
		cmd_op = ddrpi_pkg::ddrpi_op_read;
		pwr_down = 1'b0;
		repeat (7) @(posedge sys_clk);
		#1;
		check("cold_cke", cke, 1'h0);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		tick();
		tick();
		t_reset();
		t_fill_write();
		t_read();
		t_power();
		t_read();
		print_verdict();
	end
endmodule
